// >>> rtl/mwx_pkg.sv
// Package for the memory window bank expander: offsets, field layouts, reset values
package mwx_pkg;

    localparam int ADDR_W   = 16;
    localparam int LINE_W   = 6;
    localparam int AVS_AW   = 8;
    localparam int AVS_DW   = 32;

    // Register byte offsets
    localparam logic [AVS_AW-1:0] OFS_PIN_ASSIGN = 8'h00;
    localparam logic [AVS_AW-1:0] OFS_SIZE       = 8'h04;
    localparam logic [AVS_AW-1:0] OFS_BASE       = 8'h08;
    localparam logic [AVS_AW-1:0] OFS_BANK_ONE   = 8'h0C;
    localparam logic [AVS_AW-1:0] OFS_BANK_TWO   = 8'h10;
    localparam logic [AVS_AW-1:0] OFS_GPIO_OUT   = 8'h14;
    localparam logic [AVS_AW-1:0] OFS_GPIO_DIR   = 8'h18;
    localparam logic [AVS_AW-1:0] OFS_GPIO_IN    = 8'h1C;
    localparam logic [AVS_AW-1:0] OFS_STATUS     = 8'h20;

    // Field positions
    localparam int SIZE_ONE_LSB = 0;
    localparam int SIZE_TWO_LSB = 4;
    localparam int BASE_ONE_LSB = 0;
    localparam int BASE_TWO_LSB = 4;

    // Window size field encodings
    localparam logic [1:0] SZ_OFF = 2'h0;
    localparam logic [1:0] SZ_8K  = 2'h1;
    localparam logic [1:0] SZ_16K = 2'h2;
    localparam logic [1:0] SZ_32K = 2'h3;
    // Base bits 15:14 that place a 32K window at 0x4000
    localparam logic [1:0] BASE_4000 = 2'h1;

    // Reset values
    localparam logic [LINE_W-1:0] RST_PIN_ASSIGN = 6'h00;
    localparam logic [7:0]        RST_SIZE       = 8'h00;
    localparam logic [7:0]        RST_BASE       = 8'h00;
    localparam logic [LINE_W-1:0] RST_BANK       = 6'h00;

endpackage : mwx_pkg

// >>> rtl/mwx_win_if.sv
// Interface between the top and one window decoder
`timescale 1ns/1ps
interface mwx_win_if;
    import mwx_pkg::*;
    logic [1:0]        window_size_field;
    logic [2:0]        window_base_field;
    logic [LINE_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              hit;
    logic [LINE_W-1:0] lines;

    modport dec (input window_size_field, window_base_field, bank, addr, output hit, lines);
    modport ctl (output window_size_field, window_base_field, bank, addr, input hit, lines);
endinterface : mwx_win_if

// >>> rtl/mwx_window.sv
// One memory window: hit decode and expansion line values for lines 18..13
`timescale 1ns/1ps
module mwx_window
(
    mwx_win_if.dec win
);
    import mwx_pkg::*;

    logic at_4000;

    always_comb
    begin
        at_4000   = (win.window_base_field[2:1] == BASE_4000);
        win.hit   = 1'b0;
        win.lines = win.bank;
        unique case (win.window_size_field)
            SZ_OFF:
            begin
                win.hit = 1'b0;
            end
            SZ_8K:
            begin
                win.hit   = (win.addr[15:13] == win.window_base_field);
                win.lines = win.bank;
            end
            SZ_16K:
            begin
                win.hit   = (win.addr[15:14] == win.window_base_field[2:1]);
                win.lines = {win.bank[5:1], win.addr[13]};
            end
            SZ_32K:
            begin
                if (at_4000)
                begin
                    // Straddles 0x4000..0xBFFF; bit 14 flipped so memory sees it contiguous
                    win.hit   = win.addr[15] ^ win.addr[14];
                    win.lines = {win.bank[5:2], ~win.addr[14], win.addr[13]};
                end
                else
                begin
                    win.hit   = (win.addr[15] == win.window_base_field[2]);
                    win.lines = {win.bank[5:2], win.addr[14:13]};
                end
            end
        endcase
    end

endmodule : mwx_window

// >>> rtl/mwx_top.sv
// Memory window bank expander with Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module mwx_top
(
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [mwx_pkg::AVS_AW-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [mwx_pkg::AVS_DW-1:0]  avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [mwx_pkg::AVS_DW-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        cpu_valid,
    input  wire logic [mwx_pkg::ADDR_W-1:0]  cpu_addr,
    output logic      [mwx_pkg::ADDR_W-1:0]  mem_addr,
    input  wire logic [mwx_pkg::LINE_W-1:0]  pin_in,
    output logic      [mwx_pkg::LINE_W-1:0]  pin_out,
    output logic      [mwx_pkg::LINE_W-1:0]  pin_oe,
    output logic      [1:0]                  window_active
);
    import mwx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus slave

    logic [LINE_W-1:0] port_pin_assign, next_port_pin_assign;
    logic [7:0]        window_size_select, next_window_size_select;
    logic [7:0]        window_base_select, next_window_base_select;
    logic [LINE_W-1:0] window_one_bank, next_window_one_bank;
    logic [LINE_W-1:0] window_two_bank, next_window_two_bank;
    logic [LINE_W-1:0] gpio_out, next_gpio_out;
    logic [LINE_W-1:0] gpio_dir, next_gpio_dir;
    logic [AVS_DW-1:0] next_avs_readdata;
    logic              next_avs_waitrequest;
    logic              do_write;
    logic [7:0]        wbyte;

    always_comb
    begin
        next_port_pin_assign    = port_pin_assign;
        next_window_size_select = window_size_select;
        next_window_base_select = window_base_select;
        next_window_one_bank    = window_one_bank;
        next_window_two_bank    = window_two_bank;
        next_gpio_out           = gpio_out;
        next_gpio_dir           = gpio_dir;
        next_avs_readdata       = avs_readdata;
        wbyte                   = avs_writedata[7:0];
        // One wait cycle, then a one-cycle answer
        next_avs_waitrequest    = !((avs_read || avs_write) && avs_waitrequest);
        do_write                = avs_write && !avs_waitrequest && avs_byteenable[0];
        if (do_write)
        begin
            unique case (avs_address)
                OFS_PIN_ASSIGN: next_port_pin_assign    = wbyte[LINE_W-1:0];
                OFS_SIZE:       next_window_size_select = wbyte & 8'h33;
                OFS_BASE:       next_window_base_select = wbyte & 8'h77;
                OFS_BANK_ONE:   next_window_one_bank    = wbyte[LINE_W-1:0];
                OFS_BANK_TWO:   next_window_two_bank    = wbyte[LINE_W-1:0];
                OFS_GPIO_OUT:   next_gpio_out           = wbyte[LINE_W-1:0];
                OFS_GPIO_DIR:   next_gpio_dir           = wbyte[LINE_W-1:0];
                default:        next_gpio_dir           = gpio_dir;
            endcase
        end
        if (avs_read && avs_waitrequest)
        begin
            unique case (avs_address)
                OFS_PIN_ASSIGN: next_avs_readdata = {26'h0, port_pin_assign};
                OFS_SIZE:       next_avs_readdata = {24'h0, window_size_select};
                OFS_BASE:       next_avs_readdata = {24'h0, window_base_select};
                OFS_BANK_ONE:   next_avs_readdata = {26'h0, window_one_bank};
                OFS_BANK_TWO:   next_avs_readdata = {26'h0, window_two_bank};
                OFS_GPIO_OUT:   next_avs_readdata = {26'h0, gpio_out};
                OFS_GPIO_DIR:   next_avs_readdata = {26'h0, gpio_dir};
                OFS_GPIO_IN:    next_avs_readdata = {26'h0, pin_in};
                OFS_STATUS:     next_avs_readdata = {30'h0, window_active};
                default:        next_avs_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            port_pin_assign    <= RST_PIN_ASSIGN;
            window_size_select <= RST_SIZE;
            window_base_select <= RST_BASE;
            window_one_bank    <= RST_BANK;
            window_two_bank    <= RST_BANK;
            gpio_out           <= RST_PIN_ASSIGN;
            gpio_dir           <= RST_PIN_ASSIGN;
            avs_readdata       <= 32'h0000_0000;
            avs_waitrequest    <= 1'b1;
        end
        else
        begin
            port_pin_assign    <= next_port_pin_assign;
            window_size_select <= next_window_size_select;
            window_base_select <= next_window_base_select;
            window_one_bank    <= next_window_one_bank;
            window_two_bank    <= next_window_two_bank;
            gpio_out           <= next_gpio_out;
            gpio_dir           <= next_gpio_dir;
            avs_readdata       <= next_avs_readdata;
            avs_waitrequest    <= next_avs_waitrequest;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window decode

    mwx_win_if w1 ();
    mwx_win_if w2 ();

    assign w1.window_size_field = window_size_select[SIZE_ONE_LSB +: 2];
    assign w1.window_base_field = window_base_select[BASE_ONE_LSB +: 3];
    assign w1.bank              = window_one_bank;
    assign w1.addr              = cpu_addr;
    assign w2.window_size_field = window_size_select[SIZE_TWO_LSB +: 2];
    assign w2.window_base_field = window_base_select[BASE_TWO_LSB +: 3];
    assign w2.bank              = window_two_bank;
    assign w2.addr              = cpu_addr;

    mwx_window u_win_one (.win(w1.dec));
    mwx_window u_win_two (.win(w2.dec));

    ////////////////////////////////////////////////////////////////////////////
    // Line selection and pin muxing

    logic [LINE_W-1:0] line_val;
    logic [1:0]        next_window_active;
    logic [LINE_W-1:0] next_pin_out;
    logic [LINE_W-1:0] next_pin_oe;
    logic [ADDR_W-1:0] next_mem_addr;

    always_comb
    begin
        next_window_active = 2'b00;
        line_val           = {3'h0, cpu_addr[15:13]};
        if (cpu_valid && w1.hit)
        begin
            next_window_active = 2'b01;
            line_val           = w1.lines;
        end
        else if (cpu_valid && w2.hit)
        begin
            next_window_active = 2'b10;
            line_val           = w2.lines;
        end
    end

    assign next_mem_addr[12:0] = cpu_addr[12:0];

    genvar gi;
    generate
        for (gi = 0; gi < LINE_W; gi++)
        begin : g_pin
            assign next_pin_out[gi] = port_pin_assign[gi] ? line_val[gi] : gpio_out[gi];
            assign next_pin_oe[gi]  = port_pin_assign[gi] | gpio_dir[gi];
            if (gi < 3)
            begin : g_shared
                assign next_mem_addr[13+gi] = port_pin_assign[gi] ? line_val[gi] : cpu_addr[13+gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mem_addr      <= 16'h0000;
            pin_out       <= 6'h00;
            pin_oe        <= 6'h00;
            window_active <= 2'h0;
        end
        else
        begin
            mem_addr      <= next_mem_addr;
            pin_out       <= next_pin_out;
            pin_oe        <= next_pin_oe;
            window_active <= next_window_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    prio_one_a: assert property ($past(cpu_valid && w1.hit) |-> window_active == 2'b01)
        else $error("window 1 hit not given priority");
    win_two_a: assert property ($past(cpu_valid && !w1.hit && w2.hit) |-> window_active == 2'b10)
        else $error("window 2 hit not reported");
    size_off_a: assert property ($past(window_size_select[1:0] == SZ_OFF) |-> !window_active[0])
        else $error("disabled window 1 reported active");
    low_offset_a: assert property (##1 mem_addr[12:0] == $past(cpu_addr[12:0]))
        else $error("low offset bits altered");
    bank_drive_a: assert property ($past(cpu_valid && w1.hit && window_size_select[1:0] == SZ_8K)
        |-> (pin_out & $past(port_pin_assign)) == ($past(window_one_bank) & $past(port_pin_assign)))
        else $error("window 1 bank not on assigned lines");
    inv_line_a: assert property ($past(cpu_valid && w1.hit && window_size_select[1:0] == SZ_32K
        && window_base_select[2:1] == BASE_4000 && port_pin_assign[1])
        |-> pin_out[1] == !$past(cpu_addr[14]))
        else $error("line 14 not inverted in 0x4000 window");
    outside_a: assert property ($past(!(cpu_valid && (w1.hit || w2.hit)))
        |-> mem_addr[15:13] == $past(cpu_addr[15:13]))
        else $error("outside access changed upper address");
    gpio_pin_a: assert property (##1 (pin_oe == ($past(port_pin_assign) | $past(gpio_dir)))
        && ((pin_out & ~$past(port_pin_assign)) == ($past(gpio_out) & ~$past(port_pin_assign))))
        else $error("gpio pin not following its registers");
    off32_a: assert property ($past(cpu_valid && w1.hit && window_size_select[1:0] == SZ_32K
        && window_base_select[2:1] != BASE_4000 && port_pin_assign[1:0] == 2'b11)
        |-> mem_addr[14:0] == $past(cpu_addr[14:0]))
        else $error("32K offset altered");
    bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("slave did not answer after one wait cycle");

    w1_hit_c: cover property (window_active == 2'b01);
    w2_hit_c: cover property (window_active == 2'b10);
    overlap_c: cover property (cpu_valid && w1.hit && w2.hit);
    inv_c: cover property (cpu_valid && w1.hit && window_size_select[1:0] == SZ_32K
        && window_base_select[2:1] == BASE_4000);

endmodule : mwx_top

// >>> dv/mwx_mem_model.sv
// Far-side memory model: pin levels and the expanded address seen by memory
`timescale 1ns/1ps
module mwx_mem_model
(
    input  wire logic [15:0] mem_addr,
    input  wire logic [5:0]  pin_out,
    input  wire logic [5:0]  pin_oe,
    input  wire logic [5:0]  ext_level,
    output logic      [5:0]  pin_level,
    output logic      [18:0] xaddr
);
    // Undriven pins show the outside party's level
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
    // Memory takes bank lines 18..16 only where the block drives them
    assign xaddr     = {pin_level[5:3] & pin_oe[5:3], mem_addr};
endmodule : mwx_mem_model

// >>> dv/tb_mwx_top.sv
// Self-checking testbench for the memory window bank expander
`timescale 1ns/1ps
module tb_mwx_top;
    import mwx_pkg::*;
    localparam logic [7:0]  MSK [7] = '{8'h3F, 8'h33, 8'h77, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
    localparam logic [23:0] CFG [5] = '{24'h3F1332, 24'h3F2304, 24'h3F3125, 24'h070206, 24'h051370};
    logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, cpu_valid;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic [3:0]  avs_byteenable;
    logic [15:0] cpu_addr, mem_addr;
    logic [5:0]  pin_level, pin_out, pin_oe, ext, e_out, e_oe;
    logic [1:0]  window_active, e_act;
    logic [18:0] xaddr;
    logic [7:0]  r [7];
    int          err_total, n_checks, cyc;

    mwx_top mwx_top_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_valid(cpu_valid),
        .cpu_addr(cpu_addr), .mem_addr(mem_addr), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .window_active(window_active));
    mwx_mem_model mwx_mem_model_inst (.mem_addr(mem_addr), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_level(pin_level), .xaddr(xaddr));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            err_total++;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Returns {hit, line values 18..13}
    function automatic logic [6:0] dec(input logic [1:0] sz, input logic [2:0] b, input logic [5:0] k,
                                       input logic [15:0] a);
        case (sz)
            SZ_8K:   return {a[15:13] == b, k};
            SZ_16K:  return {a[15:14] == b[2:1], k[5:1], a[13]};
            SZ_32K:  if (b[2:1] == BASE_4000) return {a[15] ^ a[14], k[5:2], ~a[14], a[13]};
                     else return {a[15] == b[2], k[5:2], a[14:13]};
            default: return {1'b0, k};
        endcase
    endfunction : dec

    // Clears base bits below each window's size, except bit 14 of a 32K window at 0x4000, so software bases stay on a legal boundary
    function automatic logic [7:0] align(input logic [7:0] sz, input logic [7:0] b);
        logic [7:0] m;
        m = 8'hFF;
        for (int w = 0; w < 2; w++)
        begin
            if (sz[4*w +: 2] == SZ_16K || sz[4*w +: 2] == SZ_32K) m[4*w] = 1'b0;
            if (sz[4*w +: 2] == SZ_32K && b[4*w+1 +: 2] != BASE_4000) m[4*w+1] = 1'b0;
        end
        return b & m;
    endfunction : align

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_pin

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Waits for the answer however long it takes; only the run timeout ends a hang
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input int i, input logic [7:0] d, input logic be);
        logic [31:0] q, wd;
        wd      = rnd();
        wd[7:0] = d;
        bus(1'b1, 8'(i * 4), wd, {3'h7, be}, q);
        if (be) r[i] = d & MSK[i];
    endtask : wr

    task automatic apply(input logic [15:0] a, input logic v);
        logic [6:0]  w1, w2;
        logic        h1, h2;
        logic [5:0]  ln, pa;
        logic [15:0] ma;
        @(posedge clk);
        cpu_addr  <= a;
        cpu_valid <= v;
        ext       <= 6'(rnd());
        @(posedge clk);
        #1;
        w1 = dec(r[1][1:0], r[2][2:0], r[3][5:0], a);
        w2 = dec(r[1][5:4], r[2][6:4], r[4][5:0], a);
        h1 = w1[6] & v;
        h2 = w2[6] & v & !h1;
        ln = h1 ? w1[5:0] : h2 ? w2[5:0] : {3'h0, a[15:13]};
        pa = r[0][5:0];
        ma = a;
        for (int i = 0; i < 3; i++) if (pa[i]) ma[13 + i] = ln[i];
        e_oe  = pa | r[6][5:0];
        e_out = (pa & ln) | (~pa & r[5][5:0]);
        e_act = {h2, h1};
        chk_pin("window_active", {14'h0, e_act}, {14'h0, window_active});
        chk_pin("mem_addr", ma, mem_addr);
        chk_pin("pin_out", {10'h0, e_out}, {10'h0, pin_out});
        chk_pin("pin_oe", {10'h0, e_oe}, {10'h0, pin_oe});
        chk_pin("bank_lines_hi", {13'h0, e_oe[5:3] & e_out[5:3]}, {13'h0, xaddr[18:16]});
    endtask : apply

    task automatic rdall();
        logic [31:0] q, e;
        for (int i = 0; i < 11; i++)
        begin
            bus(1'b0, (i == 10) ? 8'hFC : 8'(i * 4), 32'h0, 4'hF, q);
            e = (i < 7) ? {24'h0, r[i]} : (i == 7) ? {26'h0, (e_oe & e_out) | (~e_oe & ext)} :
                (i == 8) ? {30'h0, e_act} : 32'h0;
            chk_reg("readdata", e, q);
        end
    endtask : rdall

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    initial
    begin
        logic [23:0] c;
        seed = 32'h0000_0060;
        {reset_n, avs_read, avs_write, cpu_valid, avs_address, avs_writedata} = '0;
        {avs_byteenable, cpu_addr, ext} = '0;
        r = '{default: 8'h00};
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        apply(16'hA5A5, 1'b1);
        rdall();
        $display("test reset done");
        for (int t = 0; t < 25; t++)
        begin
            c = (t < 5) ? CFG[t] : 24'(rnd());
            wr(0, c[23:16], t < 5 || rnd() % 8 != 0);
            wr(1, c[15:8], t < 5 || rnd() % 8 != 0);
            wr(2, align(r[1], c[7:0]), 1'b1);
            for (int i = 3; i < 7; i++) wr(i, 8'(rnd()), rnd() % 8 != 0);
            repeat (40) apply(16'(rnd()), rnd() % 4 != 0);
            rdall();
            $display("test config %0d done", t);
        end
        results();
    end
endmodule : tb_mwx_top
